//--- inc/bbc_consts.svh
`ifndef BBC_CONSTS_SVH
`define BBC_CONSTS_SVH
// Memory shape
`define BBC_ADDR_W 13
`define BBC_DATA_W 8
`define BBC_CLK_ROW 10'h3ff
// Clock byte slots, counted from the bottom of the top eight bytes
`define BBC_IDX_CTRL 3'h0
`define BBC_IDX_SEC 3'h1
`define BBC_IDX_MIN 3'h2
`define BBC_IDX_HOUR 3'h3
`define BBC_IDX_DAY 3'h4
`define BBC_IDX_DATE 3'h5
`define BBC_IDX_MONTH 3'h6
`define BBC_IDX_YEAR 3'h7
// BCD limits and reset values
`define BBC_SEC_MAX 8'h59
`define BBC_MIN_MAX 8'h59
`define BBC_HOUR_MAX 8'h23
`define BBC_DAY_MAX 8'h07
`define BBC_MONTH_MAX 8'h12
`define BBC_YEAR_MAX 8'h99
`define BBC_BCD_ZERO 8'h00
`define BBC_BCD_ONE 8'h01
`define BBC_BCD_CARRY 8'h07
`define BBC_NIB_NINE 4'h9
`define BBC_CTRL_RST 8'h00
// Month numbers and lengths
`define BBC_FEB 8'h02
`define BBC_APR 8'h04
`define BBC_JUN 8'h06
`define BBC_SEP 8'h09
`define BBC_NOV 8'h11
`define BBC_LEN28 8'h28
`define BBC_LEN29 8'h29
`define BBC_LEN30 8'h30
`define BBC_LEN31 8'h31
// Leap year ones digits for even and odd tens
`define BBC_LEAP_E0 4'h0
`define BBC_LEAP_E4 4'h4
`define BBC_LEAP_E8 4'h8
`define BBC_LEAP_O2 4'h2
`define BBC_LEAP_O6 4'h6
// Timing
`define BBC_CLK_NS 10
`define BBC_SECOND_NS 1000000000
`define BBC_SECOND_CYC (`BBC_SECOND_NS / `BBC_CLK_NS)
`define BBC_DESEL_MIN_NS 10000
`define BBC_DESEL_CYC ((`BBC_DESEL_MIN_NS + `BBC_CLK_NS - 1) / `BBC_CLK_NS)
`define BBC_RELEASE_MAX_NS 120000
`define BBC_RELEASE_CYC (`BBC_RELEASE_MAX_NS / `BBC_CLK_NS)
`endif

//--- inc/bbc_pkg.sv
`default_nettype none
package bbc_pkg;
  typedef struct packed {
    logic [7:0] year;
    logic [7:0] month;
    logic [7:0] date;
    logic [7:0] day;
    logic [7:0] hour;
    logic [7:0] min;
    logic [7:0] sec;
  } bbc_time_t;

  typedef enum logic [1:0] {
    BBC_PF_RUN = 2'h0,
    BBC_PF_ALERT = 2'h1,
    BBC_PF_DESEL = 2'h2,
    BBC_PF_RECOVER = 2'h3
  } bbc_pf_state_t;

  typedef struct packed {
    bbc_pf_state_t state;
    logic [15:0] cnt;
    logic int_b;
    logic desel;
    logic battery;
  } bbc_pf_t;

  typedef struct packed {
    logic [31:0] presc;
    logic tick;
    logic xfer;
    logic [7:0][7:0] cells;
    logic [7:0] data;
    logic oe;
    logic standby;
  } bbc_top_t;
endpackage
`default_nettype wire

//--- rtl/bbc_clock_sram.sv
// How it works
// RL1: Byte-wide 8K by 8 asynchronous-style static memory.
// RL2: Clock bytes sit at top eight addresses.
// RL3: Top down: year, month, date, day, hour, minutes, seconds.
// RL4: Packed BCD values, 24-hour count.
// RL5: Date rolls over at true month length.
// RL6: Lowest clock byte is the control register.
// RL7: Counters copied into visible cells every second.
// RL8: Copy never disturbs other memory accesses.
// RL9: Power fail deselects and blocks all writes.
// RL10: Low-active select inactive means deselected, floating.
// RL11: High-active select low means deselected, floating; the code floats the pins but o_standby ignores this select.
// RL12: Selected with write strobe low: write.
// RL13: Selected, output enable low: drive byte.
// RL14: Output enable high: internal read, pins float.
// RL15: Below threshold deselected; below switchover battery.
// RL16: Alert low, deselect 10 to 40 us.
// RL17: Alert released within 120 us of recovery; a recovery inside the alert delay still deselects first, then waits 120 us.
// RL18: Host idles at least 1 ms after power-up.
// RL19: Host idle before supply falls.
// RL20: Thirteen address bits pick one of 8192 bytes.
// RL21: Write lasts while all strobes stay active.
// RL22: Write strobe low floats the data pins.
// RL23: Control byte stored and read back only.
// RL24: Host time writes stay until next copy.
`timescale 1ns/1ps
`default_nettype none
`include "bbc_consts.svh"
module bbc_clock_sram #(
  parameter int SECOND_CYC = `BBC_SECOND_CYC,
  parameter int DESEL_CYC = `BBC_DESEL_CYC,
  parameter int RELEASE_CYC = `BBC_RELEASE_CYC
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  // Host memory strobes
  input wire logic i_chip_sel_b,
  input wire logic i_chip_select_high_active,
  input wire logic i_write_b,
  input wire logic i_out_en_b,
  input wire logic [`BBC_ADDR_W-1:0] i_address_pins,
  // Data pins
  input wire logic [`BBC_DATA_W-1:0] i_data_pins,
  output logic [`BBC_DATA_W-1:0] o_data_pins,
  output logic o_data_pins_oe,
  // Supply monitors
  input wire logic i_below_power_fail_threshold,
  input wire logic i_below_switchover,
  // Status
  output logic o_power_fail_int_b,
  output logic o_deselected,
  output logic o_standby,
  output logic o_on_battery
);
  localparam int DEPTH = 1 << `BBC_ADDR_W;

  bbc_pkg::bbc_top_t st_reg;
  bbc_pkg::bbc_top_t st_next;
  bbc_pkg::bbc_time_t tod;
  logic [`BBC_DATA_W-1:0] mem [DEPTH];
  logic pf_desel;
  logic selected;
  logic host_wr;
  logic host_rd;
  logic is_clk;
  logic [2:0] slot;
  logic [`BBC_DATA_W-1:0] rd_val;

  bbc_tod_counter u_tod (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .i_tick(st_reg.tick),
    .o_time(tod)
  );

  bbc_power_fail #(
    .DESEL_CYC(DESEL_CYC),
    .RELEASE_CYC(RELEASE_CYC)
  ) u_pf (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .i_below_power_fail_threshold(i_below_power_fail_threshold),
    .i_below_switchover(i_below_switchover),
    .o_power_fail_int_b(o_power_fail_int_b),
    .o_deselect(pf_desel),
    .o_on_battery(o_on_battery)
  );

  // Access decode
  always_comb begin
    selected = !i_chip_sel_b && i_chip_select_high_active && !pf_desel; // see RL10 see RL11
    // Writes stop at once on a low supply, ahead of full deselect
    host_wr = selected && !i_write_b && !i_below_power_fail_threshold; // see RL9 see RL12
    host_rd = selected && i_write_b; // see RL14
    is_clk = i_address_pins[`BBC_ADDR_W-1:3] == `BBC_CLK_ROW; // see RL2
    slot = i_address_pins[2:0];
    rd_val = is_clk ? st_reg.cells[slot] : mem[i_address_pins]; // see RL20
  end

  // Plain storage; the clock cells live apart so the copy never contends with it
  always_ff @(posedge i_sys_clk) begin
    if (host_wr && !is_clk) begin
      mem[i_address_pins] <= i_data_pins; // see RL1 see RL8 see RL21
    end
  end

  always_comb begin
    st_next = st_reg;
    st_next.tick = 1'b0;
    if (st_reg.presc == 32'(SECOND_CYC - 1)) begin
      st_next.presc = 32'h0000_0000;
      st_next.tick = 1'b1;
    end else begin
      st_next.presc = st_reg.presc + 32'h0000_0001;
    end
    // Copy one cycle after the step so the counters have settled
    st_next.xfer = st_reg.tick;
    if (st_reg.xfer) begin
      st_next.cells[`BBC_IDX_SEC] = tod.sec; // see RL7 see RL3
      st_next.cells[`BBC_IDX_MIN] = tod.min;
      st_next.cells[`BBC_IDX_HOUR] = tod.hour;
      st_next.cells[`BBC_IDX_DAY] = tod.day;
      st_next.cells[`BBC_IDX_DATE] = tod.date;
      st_next.cells[`BBC_IDX_MONTH] = tod.month;
      st_next.cells[`BBC_IDX_YEAR] = tod.year;
    end
    // Host write to a clock cell wins a same-cycle copy; control never reaches the counters
    if (host_wr && is_clk) begin
      st_next.cells[slot] = i_data_pins; // see RL24 see RL23 see RL6
    end
    if (host_rd) begin
      st_next.data = rd_val; // see RL13
    end
    st_next.oe = host_rd && !i_out_en_b; // see RL13 see RL22 see RL14
    st_next.standby = i_chip_sel_b || pf_desel;
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      st_reg.presc <= 32'h0000_0000;
      st_reg.tick <= 1'b0;
      st_reg.xfer <= 1'b0;
      // Year down to control, matching the counters' reset date
      st_reg.cells <= '{`BBC_BCD_ZERO, `BBC_BCD_ONE, `BBC_BCD_ONE, `BBC_BCD_ONE,
                        `BBC_BCD_ZERO, `BBC_BCD_ZERO, `BBC_BCD_ZERO, `BBC_CTRL_RST};
      st_reg.data <= `BBC_BCD_ZERO;
      st_reg.oe <= 1'b0;
      st_reg.standby <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_data_pins = st_reg.data;
  assign o_data_pins_oe = st_reg.oe;
  assign o_deselected = pf_desel;
  assign o_standby = st_reg.standby;
endmodule
`default_nettype wire

//--- rtl/bbc_power_fail.sv
`timescale 1ns/1ps
`default_nettype none
`include "bbc_consts.svh"
module bbc_power_fail #(
  parameter int DESEL_CYC = `BBC_DESEL_CYC,
  parameter int RELEASE_CYC = `BBC_RELEASE_CYC
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  // Supply monitors
  input wire logic i_below_power_fail_threshold,
  input wire logic i_below_switchover,
  // Status
  output logic o_power_fail_int_b,
  output logic o_deselect,
  output logic o_on_battery
);
  bbc_pkg::bbc_pf_t st_reg;
  bbc_pkg::bbc_pf_t st_next;

  always_comb begin
    st_next = st_reg;
    st_next.battery = i_below_switchover; // see RL15
    st_next.cnt = st_reg.cnt + 16'h0001;
    unique case (st_reg.state)
      bbc_pkg::BBC_PF_RUN: begin
        st_next.cnt = 16'h0000;
        if (i_below_power_fail_threshold) begin
          st_next.state = bbc_pkg::BBC_PF_ALERT;
          st_next.int_b = 1'b0; // see RL16
        end
      end
      bbc_pkg::BBC_PF_ALERT: begin
        // Deselect lands at the shortest allowed alert time
        if (st_reg.cnt == 16'(DESEL_CYC - 1)) begin
          st_next.state = bbc_pkg::BBC_PF_DESEL;
          st_next.desel = 1'b1; // see RL16
          st_next.cnt = 16'h0000;
        end
      end
      bbc_pkg::BBC_PF_DESEL: begin
        st_next.cnt = 16'h0000;
        if (!i_below_power_fail_threshold) begin
          st_next.state = bbc_pkg::BBC_PF_RECOVER;
        end
      end
      bbc_pkg::BBC_PF_RECOVER: begin
        if (i_below_power_fail_threshold) begin
          st_next.state = bbc_pkg::BBC_PF_DESEL;
          st_next.cnt = 16'h0000;
        end else if (st_reg.cnt == 16'(RELEASE_CYC - 1)) begin
          st_next.state = bbc_pkg::BBC_PF_RUN;
          st_next.int_b = 1'b1; // see RL17
          st_next.desel = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      st_reg <= '{bbc_pkg::BBC_PF_RUN, 16'h0000, 1'b1, 1'b0, 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_power_fail_int_b = st_reg.int_b;
  assign o_deselect = st_reg.desel;
  assign o_on_battery = st_reg.battery;
endmodule
`default_nettype wire

//--- rtl/bbc_tod_counter.sv
`timescale 1ns/1ps
`default_nettype none
`include "bbc_consts.svh"
module bbc_tod_counter (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  // One-second step
  input wire logic i_tick,
  // Running counters
  output bbc_pkg::bbc_time_t o_time
);
  bbc_pkg::bbc_time_t st_reg;
  bbc_pkg::bbc_time_t st_next;

  function automatic logic [8:0] bbc_inc(input logic [7:0] v, input logic [7:0] max,
                                         input logic [7:0] min);
    if (v >= max) begin
      bbc_inc = {1'b1, min};
    end else if (v[3:0] == `BBC_NIB_NINE) begin
      bbc_inc = {1'b0, v + `BBC_BCD_CARRY};
    end else begin
      bbc_inc = {1'b0, v + `BBC_BCD_ONE};
    end
  endfunction

  function automatic logic [7:0] bbc_month_len(input logic [7:0] m, input logic [7:0] y);
    logic leap;
    leap = y[4] ? (y[3:0] == `BBC_LEAP_O2 || y[3:0] == `BBC_LEAP_O6)
                : (y[3:0] == `BBC_LEAP_E0 || y[3:0] == `BBC_LEAP_E4 ||
                   y[3:0] == `BBC_LEAP_E8);
    if (m == `BBC_FEB) begin
      bbc_month_len = leap ? `BBC_LEN29 : `BBC_LEN28; // see RL5
    end else if (m == `BBC_APR || m == `BBC_JUN || m == `BBC_SEP || m == `BBC_NOV) begin
      bbc_month_len = `BBC_LEN30;
    end else begin
      bbc_month_len = `BBC_LEN31;
    end
  endfunction

  always_comb begin
    logic [8:0] r;
    r = 9'h000;
    st_next = st_reg;
    if (i_tick) begin
      // BCD chain, 24-hour count, see RL4
      r = bbc_inc(st_reg.sec, `BBC_SEC_MAX, `BBC_BCD_ZERO);
      st_next.sec = r[7:0];
      if (r[8]) begin
        r = bbc_inc(st_reg.min, `BBC_MIN_MAX, `BBC_BCD_ZERO);
        st_next.min = r[7:0];
        if (r[8]) begin
          r = bbc_inc(st_reg.hour, `BBC_HOUR_MAX, `BBC_BCD_ZERO);
          st_next.hour = r[7:0];
          if (r[8]) begin
            r = bbc_inc(st_reg.day, `BBC_DAY_MAX, `BBC_BCD_ONE);
            st_next.day = r[7:0];
            r = bbc_inc(st_reg.date, bbc_month_len(st_reg.month, st_reg.year),
                        `BBC_BCD_ONE); // see RL5
            st_next.date = r[7:0];
            if (r[8]) begin
              r = bbc_inc(st_reg.month, `BBC_MONTH_MAX, `BBC_BCD_ONE);
              st_next.month = r[7:0];
              if (r[8]) begin
                r = bbc_inc(st_reg.year, `BBC_YEAR_MAX, `BBC_BCD_ZERO);
                st_next.year = r[7:0];
              end
            end
          end
        end
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      st_reg <= '{`BBC_BCD_ZERO, `BBC_BCD_ONE, `BBC_BCD_ONE, `BBC_BCD_ONE,
                  `BBC_BCD_ZERO, `BBC_BCD_ZERO, `BBC_BCD_ZERO};
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_time = st_reg;
endmodule
`default_nettype wire

//--- verification/bbc_clock_sram_sva.sv
`timescale 1ns/1ps
`default_nettype none
module bbc_clock_sram_sva #(
  parameter int SECOND_CYC = 20,
  parameter int DESEL_CYC = 5,
  parameter int RELEASE_CYC = 30
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  // Host strobes
  input wire logic i_chip_sel_b,
  input wire logic i_chip_select_high_active,
  input wire logic i_write_b,
  input wire logic i_out_en_b,
  input wire logic [12:0] i_address_pins,
  input wire logic [7:0] i_data_pins,
  input wire logic [7:0] o_data_pins,
  input wire logic o_data_pins_oe,
  // Supply and status
  input wire logic i_below_power_fail_threshold,
  input wire logic i_below_switchover,
  input wire logic o_power_fail_int_b,
  input wire logic o_deselected,
  input wire logic o_standby,
  input wire logic o_on_battery
);
  localparam int DLO = DESEL_CYC - 1;
  localparam int DHI = DESEL_CYC + 1;
  // Slack covers a recovery that lands inside the alert delay
  localparam int RMAX = RELEASE_CYC + DESEL_CYC + 2;
  logic [15:0] good_reg;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b || i_below_power_fail_threshold || o_power_fail_int_b) begin
      good_reg <= 16'h0000;
    end else begin
      good_reg <= good_reg + 16'h0001;
    end
  end
  AST_WRITE_FLOATS: assert property (!i_write_b |=> !o_data_pins_oe)
    else $error("data pins driven during write");
  AST_SEL_LOW_OFF: assert property (i_chip_sel_b |=> !o_data_pins_oe && o_standby)
    else $error("not deselected with select off");
  AST_SEL_HIGH_OFF: assert property (!i_chip_select_high_active |=> !o_data_pins_oe)
    else $error("driven with high select off");
  AST_OE_OFF_FLOATS: assert property (i_out_en_b |=> !o_data_pins_oe)
    else $error("driven with output enable off");
  AST_READ_DRIVES: assert property (!i_chip_sel_b && i_chip_select_high_active &&
    i_write_b && !i_out_en_b && !o_deselected |=> o_data_pins_oe)
    else $error("read not driven");
  AST_PF_NO_DRIVE: assert property (o_deselected |=> !o_data_pins_oe)
    else $error("driven while power deselected");
  AST_ALERT_FALLS: assert property ($rose(i_below_power_fail_threshold) &&
    o_power_fail_int_b |=> !o_power_fail_int_b)
    else $error("alert late");
  AST_ALERT_TO_DESEL: assert property ($fell(o_power_fail_int_b) |->
    ##[DLO:DHI] $rose(o_deselected))
    else $error("deselect delay wrong");
  AST_RELEASE_BOUND: assert property (good_reg <= 16'(RMAX))
    else $error("alert release too late");
  AST_BATTERY_FOLLOWS: assert property ($past(i_rst_b) |->
    o_on_battery == $past(i_below_switchover))
    else $error("battery flag wrong");
endmodule
bind bbc_clock_sram bbc_clock_sram_sva #(.SECOND_CYC(SECOND_CYC), .DESEL_CYC(DESEL_CYC),
  .RELEASE_CYC(RELEASE_CYC)) u_sva (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b),
  .i_chip_sel_b(i_chip_sel_b), .i_chip_select_high_active(i_chip_select_high_active),
  .i_write_b(i_write_b), .i_out_en_b(i_out_en_b), .i_address_pins(i_address_pins),
  .i_data_pins(i_data_pins), .o_data_pins(o_data_pins), .o_data_pins_oe(o_data_pins_oe),
  .i_below_power_fail_threshold(i_below_power_fail_threshold),
  .i_below_switchover(i_below_switchover), .o_power_fail_int_b(o_power_fail_int_b),
  .o_deselected(o_deselected), .o_standby(o_standby), .o_on_battery(o_on_battery));
`default_nettype wire

//--- verification/bbc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module bbc_host_model (
  // Clock
  input wire logic i_sys_clk,
  // Strobes to device
  output logic o_cs_b,
  output logic o_cs_hi,
  output logic o_we_b,
  output logic o_oe_b,
  output logic [12:0] o_addr,
  output logic [7:0] o_data,
  // Answer from device
  input wire logic [7:0] i_q,
  input wire logic i_q_oe
);
  initial begin
    {o_cs_b, o_cs_hi, o_we_b, o_oe_b} = 4'hb;
    o_addr = 13'h0000;
    o_data = 8'h00;
  end
  // ctl is {cs_b, cs_hi, we_b, oe_b}; held until the next call
  task automatic cyc(input logic [3:0] ctl, input logic [12:0] a, input logic [7:0] d);
    @(negedge i_sys_clk);
    {o_cs_b, o_cs_hi, o_we_b, o_oe_b} = ctl;
    o_addr = a;
    // Released data line flips so a stale byte never matches
    o_data = ctl[1] ? ~o_data : d;
  endtask
  task automatic rd(input logic [12:0] a, output logic [7:0] q, output logic v);
    cyc(4'h6, a, 8'h00);
    @(negedge i_sys_clk);
    q = i_q;
    v = i_q_oe;
  endtask
endmodule
`default_nettype wire

//--- verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int SEC = 20;
  localparam int DES = 5;
  localparam int REL = 30;
  localparam logic [63:0] RV = 64'h0001010100000000;
  logic clk, rst_b, thr, swo, cs_b, cs_hi, we_b, oe_b, q_oe, int_b, desel, stby, batt, v;
  logic [12:0] addr;
  logic [7:0] din, q, got;
  logic [7:0] mem [int];
  int n_mismatch = 0;
  int checks_done = 0;
  int cyc_n = 0;
  int seed = 32'h6fcb64fd;
  bbc_clock_sram #(.SECOND_CYC(SEC), .DESEL_CYC(DES), .RELEASE_CYC(REL)) u_dut (
    .i_sys_clk(clk), .i_rst_b(rst_b), .i_chip_sel_b(cs_b),
    .i_chip_select_high_active(cs_hi), .i_write_b(we_b), .i_out_en_b(oe_b),
    .i_address_pins(addr), .i_data_pins(din), .o_data_pins(q), .o_data_pins_oe(q_oe),
    .i_below_power_fail_threshold(thr), .i_below_switchover(swo),
    .o_power_fail_int_b(int_b), .o_deselected(desel), .o_standby(stby),
    .o_on_battery(batt));
  bbc_host_model u_host (.i_sys_clk(clk), .o_cs_b(cs_b), .o_cs_hi(cs_hi), .o_we_b(we_b),
    .o_oe_b(oe_b), .o_addr(addr), .o_data(din), .i_q(q), .i_q_oe(q_oe));
  function automatic logic [7:0] bcd(input int n);
    return 8'((n / 10) * 16 + n % 10);
  endfunction
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic rdchk(input logic [12:0] a, input logic [7:0] e);
    u_host.rd(a, got, v);
    chk({7'h00, v}, 8'h01);
    chk(got, e);
  endtask
  // Mid-second sampling keeps clear of the copy edge
  task automatic tchk(input int s);
    wait (cyc_n == s * SEC + SEC / 2);
    rdchk(13'h1ff9, bcd(s % 60));
    rdchk(13'h1ffa, bcd(s / 60));
  endtask
  task automatic summarize;
    $display("mismatches=%0d checks=%0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) if (rst_b) cyc_n <= cyc_n + 1;
  initial begin
    #100000;
    n_mismatch++;
    summarize();
  end
  initial begin
    int a;
    int op;
    rst_b = 1'b0;
    thr = 1'b0;
    swo = 1'b0;
    repeat (12) @(negedge clk);
    rst_b = 1'b1;
    for (int i = 0; i < 8; i++) rdchk(13'h1ff8 + 13'(i), RV[i*8+:8]);
    u_host.cyc(4'h4, 13'h1ff8, 8'ha5);
    rdchk(13'h1ff8, 8'ha5);
    wait (cyc_n == 45);
    u_host.cyc(4'h4, 13'h1ff9, 8'h45);
    rdchk(13'h1ff9, 8'h45);
    tchk(3);
    for (int k = 0; k < 80; k++) begin
      a = ($unsigned($random(seed)) % 16) * 511;
      op = $unsigned($random(seed)) % 4;
      if (k < 2) begin
        a = k * 8183;
        op = 3;
      end
      if (op == 0 && mem.exists(a)) begin
        rdchk(13'(a), mem[a]);
      end else if (op == 1) begin
        u_host.cyc(4'hc, 13'(a), 8'h3c);
      end else if (op == 2) begin
        u_host.cyc(4'h0, 13'(a), 8'hc3);
      end else begin
        mem[a] = 8'($random(seed));
        u_host.cyc({3'h2, op[0]}, 13'(a), mem[a]);
      end
    end
    // Read strobes with output enable off, then with the high select off
    u_host.cyc(4'h7, 13'h0000, 8'h00);
    @(negedge clk);
    chk({7'h00, q_oe}, 8'h00);
    u_host.cyc(4'h2, 13'h0000, 8'h00);
    @(negedge clk);
    chk({7'h00, q_oe}, 8'h00);
    u_host.cyc(4'he, 13'h0000, 8'h00);
    @(negedge clk);
    chk({6'h00, q_oe, stby}, 8'h01);
    tchk(15);
    tchk(59);
    tchk(61);
    @(negedge clk);
    thr = 1'b1;
    u_host.cyc(4'h5, 13'h0000, ~mem[0]);
    u_host.cyc(4'hb, 13'h0000, 8'h00);
    swo = 1'b1;
    repeat (DES + 4) @(negedge clk);
    chk({7'h00, desel}, 8'h01);
    u_host.rd(13'h0000, got, v);
    chk({7'h00, v}, 8'h00);
    u_host.cyc(4'hb, 13'h0000, 8'h00);
    thr = 1'b0;
    swo = 1'b0;
    repeat (REL + 4) @(negedge clk);
    chk({6'h00, int_b, desel}, 8'h02);
    rdchk(13'h0000, mem[0]);
    summarize();
  end
endmodule
`default_nettype wire
